// >>> rtl/cfg_pkg.sv
// Function
// RULE_01: restart input low starts configuration sequence
// RULE_02: host waits for ready high before restarting
// RULE_03: capture mode pins at ready rising edge
// RULE_04: ready indication is open-drain, released when ready
// RULE_05: open-drain done shows load finished, startup
// RULE_06: selected port locks until power-up
// RULE_07: jtag port only after enable instruction
// RULE_08: slave modes clock from slave clock input
// RULE_09: master modes drive generated master clock
// RULE_10: pause low tri-states serial output quickly; the loader floats it 2-3 cycles after the pause pin
// RULE_11: master clock frequency exact, duty near half
// RULE_12: pause suspends slave spi shifting, resumes
//
// Purpose: shared constants and types of the configuration sequencer
// Assumes: 20 MHz system clock, power-up reset on nrst
// Notes:   mode encodings and timing figures gathered here
package cfg_pkg;
  localparam int CLK_MHZ     = 20;
  localparam int INIT_NS     = 1000;  // ready held low after restart
  localparam int STARTUP_NS  = 500;   // startup phase after done
  localparam int HOLD_Z_NS   = 9;     // longest pause-to-output time
  localparam int INIT_CYC_I  = (INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int START_CYC_I = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC_I  = ((HOLD_Z_NS * CLK_MHZ) / 1000 < 1) ? 1 :
                               (HOLD_Z_NS * CLK_MHZ) / 1000;
  localparam logic [7:0]  INIT_CYC  = 8'(INIT_CYC_I);
  localparam logic [7:0]  START_CYC = 8'(START_CYC_I);
  localparam logic [7:0]  CNT_ONE   = 8'h01;
  localparam logic [15:0] LOAD_BITS = 16'h0040;  // bits in one image
  localparam logic [15:0] BIT_ONE   = 16'h0001;
  localparam int          SHIFT_W   = 16;
  localparam int          MODE_W    = 3;
  // configuration mode codes
  localparam logic [2:0] MODE_SPI   = 3'h0;
  localparam logic [2:0] MODE_MULTI_BOOT_SPI_MODE  = 3'h1;  // multi_boot_spi_mode
  localparam logic [2:0] MODE_MSER  = 3'h2;  // master serial
  localparam logic [2:0] MODE_SSPI  = 3'h3;  // slave spi
  localparam logic [2:0] MODE_SSER  = 3'h5;  // slave serial
  localparam logic [2:0] MODE_CPU   = 3'h7;
  // master clock half periods in system cycles, per frequency setting
  localparam logic [7:0] MCLK_HALF0 = 8'h01;  // 10 MHz
  localparam logic [7:0] MCLK_HALF1 = 8'h02;  // 5 MHz
  localparam logic [7:0] MCLK_HALF2 = 8'h04;  // 2.5 MHz
  localparam logic [7:0] MCLK_HALF3 = 8'h0a;  // 1 MHz
  // positions inside the synchroniser vector
  localparam int NSYNC   = 9;
  localparam int SY_RST  = 0;
  localparam int SY_RDY  = 1;
  localparam int SY_DONE = 2;
  localparam int SY_SCLK = 3;
  localparam int SY_PAUS = 4;
  localparam int SY_DIN  = 5;
  localparam int SY_MODE = 6;
  typedef enum logic [1:0] {PORT_NONE, PORT_PINS, PORT_JTAG} port_e;
  typedef enum logic [2:0] {S_INIT, S_WAIT, S_LOAD, S_DONE, S_STARTUP, S_USER} seq_e;

  function automatic logic is_master(input logic [2:0] m);
    return (m == MODE_SPI) || (m == MODE_MULTI_BOOT_SPI_MODE) || (m == MODE_MSER);
  endfunction
endpackage

// >>> rtl/mclk_if.sv
// Purpose: carries the master clock request and its edges
// Assumes: one system clock domain
// Notes:   rise is a one-cycle pulse with each master clock rising edge
`timescale 1ns/1ps
`default_nettype none
interface mclk_if;
  logic       run;
  logic [7:0] half_div;
  logic       mclk;
  logic       rise;
  modport gen  (input run, input half_div, output mclk, output rise);
  modport user (output run, output half_div, input mclk, input rise);
endinterface
`default_nettype wire

// >>> rtl/mclk_gen.sv
// Purpose: divides the system clock into the master configuration clock
// Assumes: half_div stays constant while run is high
// Notes:   equal high and low halves give an exact 50 percent duty
`timescale 1ns/1ps
`default_nettype none
module mclk_gen (
  input wire logic clk,
  input wire logic nrst,
  mclk_if.gen      mif
);
  import cfg_pkg::*;

  logic [7:0] div_reg;
  logic       mclk_reg;
  logic       rise_reg;
  logic [7:0] hi_len_reg;

  // toggle every half period; stopped clock idles low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_reg  <= '0;
      mclk_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else if (!mif.run) begin
      div_reg  <= '0;
      mclk_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else if (div_reg == mif.half_div - CNT_ONE) begin  // see RULE_11
      div_reg  <= '0;
      mclk_reg <= !mclk_reg;
      rise_reg <= !mclk_reg;
    end else begin
      div_reg  <= div_reg + CNT_ONE;
      rise_reg <= 1'b0;
    end
  end

  assign mif.mclk = mclk_reg;
  assign mif.rise = rise_reg;

  // helper: length of the current high phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi_len_reg <= '0;
    end else begin
      hi_len_reg <= mclk_reg ? hi_len_reg + CNT_ONE : '0;
    end
  end

  property p_duty;
    @(posedge clk) disable iff (!nrst)
      (mclk_reg && mif.run && div_reg == mif.half_div - CNT_ONE)
        |-> hi_len_reg == mif.half_div - CNT_ONE;
  endproperty
  a_duty: assert property (p_duty) else $error("master clock high wrong"); // see RULE_11
endmodule
`default_nettype wire

// >>> rtl/config_port_sequencing.sv
// Purpose: restart, ready, done, mode capture and port lock of the loader
// Assumes: all pins asynchronous to clk; jtag strobes come from clk domain
// Notes:   pin inputs pass two flops, so pin reactions lag by 2-3 cycles
`timescale 1ns/1ps
`default_nettype none
module config_port_sequencing (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               config_restart_n,
  input  wire logic [2:0]         cfg_mode,
  input  wire logic               ready_for_config_i,
  output logic                    ready_for_config_o,
  output logic                    ready_for_config_oe,
  input  wire logic               done_i,
  output logic                    done_o,
  output logic                    done_oe,
  input  wire logic               slave_cfg_clock,
  output logic                    master_clk_out,
  input  wire logic [1:0]         mclk_freq_sel,
  input  wire logic               serial_pause_n,
  input  wire logic               serial_din,
  output logic                    serial_dout_o,
  output logic                    serial_dout_oe,
  input  wire logic               jtag_cfg_enable,
  input  wire logic               jtag_bit,
  input  wire logic               jtag_bit_valid,
  output logic [2:0]              active_mode,
  output cfg_pkg::port_e          active_port,
  output logic [cfg_pkg::SHIFT_W-1:0] cfg_shift,
  output logic                    user_mode
);
  import cfg_pkg::*;

  logic [NSYNC-1:0]  sy_in;
  logic [NSYNC-1:0]  sy1_reg;
  logic [NSYNC-1:0]  sy2_reg;
  logic              rdy_hist_reg;
  logic              done_hist_reg;
  logic              sclk_hist_reg;
  logic              restart_s;
  logic              pause_s;
  logic              rdy_rise;
  logic              done_rise;
  logic              sclk_rise;
  seq_e              state_reg;
  port_e             port_reg;
  logic [2:0]        mode_reg;
  logic [7:0]        tcnt_reg;
  logic [15:0]       bit_cnt_reg;
  logic [SHIFT_W-1:0] shift_reg;
  logic              rdy_oe_reg;
  logic              done_oe_reg;
  logic              dout_reg;
  logic              dout_oe_reg;
  logic              bit_evt;
  logic              bit_val;
  logic              shift_ok;
  mclk_if            mif ();

  assign sy_in = {cfg_mode, serial_din, serial_pause_n, slave_cfg_clock,
                  done_i, ready_for_config_i, config_restart_n};

  // two-flop synchronisers, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          sy1_reg[gi] <= 1'b1;
          sy2_reg[gi] <= 1'b1;
        end else begin
          sy1_reg[gi] <= sy_in[gi];
          sy2_reg[gi] <= sy1_reg[gi];
        end
      end
    end
  endgenerate

  // edge history on synchronised levels only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_hist_reg  <= 1'b1;
      done_hist_reg <= 1'b1;
      sclk_hist_reg <= 1'b1;
    end else begin
      rdy_hist_reg  <= sy2_reg[SY_RDY];
      done_hist_reg <= sy2_reg[SY_DONE];
      sclk_hist_reg <= sy2_reg[SY_SCLK];
    end
  end

  assign restart_s = sy2_reg[SY_RST];
  assign pause_s   = sy2_reg[SY_PAUS];
  assign rdy_rise  = sy2_reg[SY_RDY] && !rdy_hist_reg;
  assign done_rise = sy2_reg[SY_DONE] && !done_hist_reg;
  assign sclk_rise = sy2_reg[SY_SCLK] && !sclk_hist_reg;

  // master clock only while loading from pins in a master mode
  assign mif.run = (state_reg == S_LOAD) && (port_reg == PORT_PINS)
                   && is_master(mode_reg);  // see RULE_09
  always_comb begin
    case (mclk_freq_sel)
      2'h0:    mif.half_div = MCLK_HALF0;
      2'h1:    mif.half_div = MCLK_HALF1;
      2'h2:    mif.half_div = MCLK_HALF2;
      default: mif.half_div = MCLK_HALF3;
    endcase
  end

  mclk_gen u_mclk (
    .clk  (clk),
    .nrst (nrst),
    .mif  (mif)
  );

  // bit source depends on the locked port and on the mode
  always_comb begin
    if (port_reg == PORT_JTAG) begin
      bit_evt = jtag_bit_valid;
      bit_val = jtag_bit;
    end else if (is_master(mode_reg)) begin
      bit_evt = mif.rise;
      bit_val = sy2_reg[SY_DIN];
    end else begin
      bit_evt = sclk_rise;  // see RULE_08
      bit_val = sy2_reg[SY_DIN];
    end
  end
  // slave spi freezes in place while paused, nothing is dropped
  assign shift_ok = !((port_reg == PORT_PINS) && (mode_reg == MODE_SSPI)
                      && !pause_s);  // see RULE_12

  // sequencer; restart from the pin overrides every state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_INIT;
      tcnt_reg  <= '0;
    end else if (!restart_s) begin
      state_reg <= S_INIT;  // see RULE_01
      tcnt_reg  <= '0;
    end else begin
      case (state_reg)
        S_INIT: begin
          if (tcnt_reg == INIT_CYC - CNT_ONE) begin
            state_reg <= S_WAIT;
            tcnt_reg  <= '0;
          end else begin
            tcnt_reg <= tcnt_reg + CNT_ONE;
          end
        end
        S_WAIT: begin
          if (rdy_rise || (port_reg == PORT_NONE && jtag_cfg_enable)) begin
            state_reg <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (bit_evt && shift_ok && bit_cnt_reg == LOAD_BITS - BIT_ONE) begin
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          if (done_rise) begin
            state_reg <= S_STARTUP;
            tcnt_reg  <= '0;
          end
        end
        S_STARTUP: begin
          if (tcnt_reg == START_CYC - CNT_ONE) begin
            state_reg <= S_USER;
          end else begin
            tcnt_reg <= tcnt_reg + CNT_ONE;
          end
        end
        S_USER:  state_reg <= S_USER;
        default: state_reg <= S_INIT;
      endcase
    end
  end

  // mode latch at the ready rising edge; host keeps restart spacing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= MODE_SPI;
    end else if (state_reg == S_WAIT && rdy_rise) begin
      mode_reg <= sy2_reg[SY_MODE +: MODE_W];  // see RULE_03
    end
  end

  // first port chosen stays until power-up; restart does not free it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_reg <= PORT_NONE;
    end else if (port_reg == PORT_NONE && restart_s && state_reg == S_WAIT) begin
      if (jtag_cfg_enable) begin
        port_reg <= PORT_JTAG;  // see RULE_07
      end else if (rdy_rise) begin
        port_reg <= PORT_PINS;  // see RULE_06
      end
    end
  end

  // shifter and bit counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (state_reg != S_LOAD) begin
      bit_cnt_reg <= '0;
    end else if (bit_evt && shift_ok) begin
      shift_reg   <= {shift_reg[SHIFT_W-2:0], bit_val};
      bit_cnt_reg <= bit_cnt_reg + BIT_ONE;
    end
  end

  // open-drain drives: oe high pulls the pin low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_oe_reg  <= 1'b1;
      done_oe_reg <= 1'b1;
    end else begin
      rdy_oe_reg  <= (state_reg == S_INIT) || !restart_s;  // see RULE_04
      done_oe_reg <= (state_reg == S_INIT) || (state_reg == S_WAIT)
                     || (state_reg == S_LOAD);  // see RULE_05
    end
  end

  // serial output forwards the oldest bit; pause floats it one cycle after the synchronised pause
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dout_reg    <= 1'b0;
      dout_oe_reg <= 1'b0;
    end else begin
      dout_reg    <= shift_reg[SHIFT_W-1];
      dout_oe_reg <= pause_s && (port_reg == PORT_PINS);  // see RULE_10
    end
  end

  assign ready_for_config_o  = 1'b0;
  assign ready_for_config_oe = rdy_oe_reg;
  assign done_o              = 1'b0;
  assign done_oe             = done_oe_reg;
  assign master_clk_out      = mif.mclk;
  assign serial_dout_o       = dout_reg;
  assign serial_dout_oe      = dout_oe_reg;
  assign active_mode         = mode_reg;
  assign active_port         = port_reg;
  assign cfg_shift           = shift_reg;
  assign user_mode           = (state_reg == S_USER);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_load_end;
    state_reg == S_LOAD ##1 state_reg == S_DONE;
  endsequence
  sequence s_init_end;
    state_reg == S_INIT ##1 state_reg == S_WAIT;
  endsequence

  property p_restart;
    !restart_s |=> state_reg == S_INIT;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored"); // see RULE_01
  property p_mode_cap;
    (state_reg == S_WAIT && rdy_rise && restart_s)
      |=> mode_reg == $past(sy2_reg[SY_MODE +: MODE_W]);
  endproperty
  a_mode_cap: assert property (p_mode_cap) else $error("mode not captured"); // see RULE_03
  property p_ready_rel;
    s_init_end ##0 restart_s |=> !rdy_oe_reg;
  endproperty
  a_ready_rel: assert property (p_ready_rel) else $error("ready not released"); // see RULE_04
  property p_done;
    s_load_end ##0 restart_s |=> !done_oe_reg;
  endproperty
  a_done: assert property (p_done) else $error("done not released"); // see RULE_05
  property p_lock;
    (port_reg != PORT_NONE) |=> port_reg == $past(port_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("port lock broken"); // see RULE_06
  property p_jtag;
    $rose(port_reg == PORT_JTAG) |-> $past(jtag_cfg_enable);
  endproperty
  a_jtag: assert property (p_jtag) else $error("jtag selected without enable"); // see RULE_07
  property p_slave_clk;
    (port_reg == PORT_PINS && !is_master(mode_reg)) |-> !mif.mclk;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("master clock in slave"); // see RULE_08
  property p_mclk;
    $rose(mif.run) |-> ##[1:21] (mif.rise || !mif.run);
  endproperty
  a_mclk: assert property (p_mclk) else $error("master clock not started"); // see RULE_09
  property p_hold;
    !pause_s |=> !serial_dout_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("output driven during pause"); // see RULE_10
  property p_pause_shift;
    (state_reg == S_LOAD && port_reg == PORT_PINS && mode_reg == MODE_SSPI && !pause_s)
      |=> $stable(bit_cnt_reg);
  endproperty
  a_pause_shift: assert property (p_pause_shift) else $error("shift during pause"); // see RULE_12
endmodule
`default_nettype wire

// >>> tb/cfg_host_model.sv
// Purpose: host, boot memory and board wiring on the far side of the loader
// Assumes: open-drain ready and done wires carry pull-ups
// Notes:   slave clock runs only inside frames, 400 ns period
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input  wire logic ready_oe,
  input  wire logic ready_o,
  input  wire logic done_oe,
  input  wire logic done_o,
  input  wire logic master_clk,
  input  wire logic hold_ready,
  input  wire logic mem_on,
  output logic      ready_w,
  output logic      done_w,
  output logic      restart_n,
  output logic      sclk,
  output logic      din,
  output logic      pause_n
);
  // wired-and of the open-drain drivers; hold_ready lets the host keep ready low
  assign ready_w = hold_ready ? 1'b0 : (ready_oe ? ready_o : 1'b1);
  assign done_w  = done_oe ? done_o : 1'b1;
  initial begin
    restart_n = 1'b1;
    sclk      = 1'b0;
    din       = 1'b0;
    pause_n   = 1'b1;
  end
  // erased boot memory answers ones on each falling master clock
  always @(negedge master_clk) begin
    if (mem_on) din <= 1'b1;
  end
  // a restart is only issued once ready has come back high
  task automatic restart();
    while (ready_w !== 1'b1) #50;
    restart_n = 1'b0;
    #250 restart_n = 1'b1;
  endtask
  // msb first, data changes while the slave clock is low
  task automatic send_bits(input logic [63:0] img, input int hi, input int lo);
    for (int i = hi; i >= lo; i--) begin
      din = img[i];
      #100 sclk = 1'b1;
      #200 sclk = 1'b0;
      #100;
    end
    din = ~din; // line is flipped so no stale data bit stays on it
  endtask
  // clock edges during pause carry junk that must not be shifted
  task automatic pause_burst(input int n);
    pause_n = 1'b0;
    #300;
    for (int i = 0; i < n; i++) begin
      din = ~din;
      #100 sclk = 1'b1;
      #200 sclk = 1'b0;
      #100;
    end
    pause_n = 1'b1;
    #300;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the configuration port sequencer
// Assumes: 20 MHz clock, slave clock from the host model
// Notes:   each finished load is compared against a queued expectation
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cfg_pkg::*;
  typedef struct packed {logic [15:0] shift; logic [2:0] mode; port_e port;} note_s;
  logic clk, nrst, jtag_en, jtag_bit, jtag_valid, hold_ready, mem_on;
  logic ready_w, done_w, restart_n, sclk, din, pause_n;
  logic rdy_o, rdy_oe, dn_o, dn_oe, mclk, dout, dout_oe, user_mode;
  logic [2:0] cfg_mode, active_mode;
  logic [1:0] freq_sel;
  logic [15:0] cfg_shift;
  logic [63:0] img;
  logic [7:0] halves [4];
  port_e active_port;
  note_s notes [$];
  note_s nt;
  int error_cnt, n_checks, seed, mclk_rises, cnt;

  config_port_sequencing uut (.clk(clk), .nrst(nrst), .config_restart_n(restart_n),
    .cfg_mode(cfg_mode), .ready_for_config_i(ready_w), .ready_for_config_o(rdy_o),
    .ready_for_config_oe(rdy_oe), .done_i(done_w), .done_o(dn_o), .done_oe(dn_oe),
    .slave_cfg_clock(sclk), .master_clk_out(mclk), .mclk_freq_sel(freq_sel),
    .serial_pause_n(pause_n), .serial_din(din), .serial_dout_o(dout),
    .serial_dout_oe(dout_oe), .jtag_cfg_enable(jtag_en), .jtag_bit(jtag_bit),
    .jtag_bit_valid(jtag_valid), .active_mode(active_mode), .active_port(active_port),
    .cfg_shift(cfg_shift), .user_mode(user_mode));
  cfg_host_model host (.ready_oe(rdy_oe), .ready_o(rdy_o), .done_oe(dn_oe), .done_o(dn_o),
    .master_clk(mclk), .hold_ready(hold_ready), .mem_on(mem_on), .ready_w(ready_w),
    .done_w(done_w), .restart_n(restart_n), .sclk(sclk), .din(din), .pause_n(pause_n));

  // free running system clock
  always #25 clk = ~clk;
  // master clock rises are counted per load
  always @(posedge mclk) mclk_rises++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // high and low halves of the master clock in system cycles
  task automatic measure_mclk(input logic [7:0] half);
    @(posedge mclk);
    #1 cnt = 0;
    while (mclk === 1'b1 && cnt < 40) begin @(posedge clk); #1 cnt++; end
    check("mclk high", cnt, half);
    cnt = 0;
    while (mclk === 1'b0 && cnt < 40) begin @(posedge clk); #1 cnt++; end
    check("mclk low", cnt, half);
  endtask

  // when done rises (dn_oe falls) a load has finished: match it with the oldest note
  always @(negedge dn_oe) begin
    #1;
    if (notes.size() == 0) begin
      check("unexpected load", 1, 0);
    end else begin
      nt = notes.pop_front();
      check("cfg_shift", cfg_shift, nt.shift);
      check("active_mode", active_mode, nt.mode);
      check("active_port", active_port, nt.port);
      check("serial_dout", dout, nt.shift[15]);
    end
  end

  // the run should end well before this
  initial begin
    #1000000;
    error_cnt++;
    $display("ERROR watchdog expired");
    wrap_up();
  end

  initial begin
    clk = 0; nrst = 0; jtag_en = 0; jtag_bit = 0; jtag_valid = 0;
    hold_ready = 1; mem_on = 0; cfg_mode = MODE_SSER; freq_sel = 2'h0;
    seed = 32'hd61540f3;
    halves = '{MCLK_HALF0, MCLK_HALF1, MCLK_HALF2, MCLK_HALF3};
    repeat (6) @(posedge clk);
    #2;
    check("ready_oe rst", rdy_oe, 1);
    check("done_oe rst", dn_oe, 1);
    check("od data", {rdy_o, dn_o}, 2'h0);
    check("port rst", active_port, PORT_NONE);
    nrst = 1;
    // jtag load while the host holds ready low
    tick(30);
    check("port before jtag", active_port, PORT_NONE);
    jtag_en = 1;
    tick(1);
    jtag_en = 0;
    tick(2);
    check("port jtag", active_port, PORT_JTAG);
    img = {$random(seed), $random(seed)};
    notes.push_back('{img[15:0], 3'h0, PORT_JTAG});
    for (int i = 63; i >= 0; i--) begin
      jtag_bit = img[i];
      jtag_valid = 1;
      tick(1);
      jtag_valid = 0;
      tick(1);
    end
    tick(20);
    check("user after jtag", user_mode, 1);
    hold_ready = 0;
    // a restart with ready rising must keep the jtag choice
    host.restart();
    tick(35);
    check("jtag lock", active_port, PORT_JTAG);
    // power-up again, slave serial through the pins
    nrst = 0;
    tick(2);
    nrst = 1;
    tick(35);
    check("mode sser", active_mode, MODE_SSER);
    check("port pins", active_port, PORT_PINS);
    cfg_mode = MODE_CPU;
    jtag_en = 1;
    tick(1);
    jtag_en = 0;
    mclk_rises = 0;
    img = {$random(seed), $random(seed)};
    notes.push_back('{img[15:0], MODE_SSER, PORT_PINS});
    host.send_bits(img, 63, 0);
    tick(20);
    check("no mclk slave", mclk_rises, 0);
    check("pins lock", active_port, PORT_PINS);
    check("user after pins", user_mode, 1);
    // restart into master spi, memory answers on the master clock
    cfg_mode = MODE_SPI;
    freq_sel = 2'($random(seed));
    mem_on = 1;
    host.restart();
    check("ready_oe restart", rdy_oe, 1);
    check("done_oe restart", dn_oe, 1);
    mclk_rises = 0;
    notes.push_back('{16'hffff, MODE_SPI, PORT_PINS});
    measure_mclk(halves[freq_sel]);
    cnt = 0;
    while (dn_oe !== 1'b0 && cnt < 3000) begin tick(1); cnt++; end
    tick(5);
    check("mclk rises", mclk_rises, 64);
    mem_on = 0;
    // restart into slave spi with a pause in mid-frame
    cfg_mode = MODE_SSPI;
    host.restart();
    // ready held low keeps the sequencer waiting; jtag must not take the port now
    hold_ready = 1;
    tick(30);
    jtag_en = 1;
    tick(1);
    jtag_en = 0;
    hold_ready = 0;
    tick(8);
    check("pins lock in wait", active_port, PORT_PINS);
    img = {$random(seed), $random(seed)};
    notes.push_back('{img[15:0], MODE_SSPI, PORT_PINS});
    host.send_bits(img, 63, 40);
    fork
      host.pause_burst(5);
      begin
        tick(6);
        check("dout_oe paused", dout_oe, 0);
      end
    join
    check("dout_oe resumed", dout_oe, 1);
    check("no early done", dn_oe, 1);
    host.send_bits(img, 39, 0);
    tick(10);
    check("notes left", notes.size(), 0);
    wrap_up();
  end
endmodule
`default_nettype wire
